// [adc_power_output_config_regs.sv]
// Control registers, power-state decode and output-bus steering.
`timescale 1ns/1ps
`default_nettype none
module adc_power_output_config_regs
   import cfg_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire logic                sclk,
   input  wire logic                csN,
   input  wire logic                sdioIn,
   output logic                     sdioOut,
   output logic                     sdioOeN,
   input  wire logic                powerDownPin,
   input  wire logic                dllLocked,
   input  wire logic [SAMPLE_W-1:0] firstSample,
   input  wire logic [SAMPLE_W-1:0] secondSample,
   input  wire logic                sampleValid,
   input  wire logic                overRange,
   output powerState_t              powerState,
   output logic [SAMPLE_W-1:0]      firstBus,
   output logic                     firstBusOeN,
   output logic [SAMPLE_W-1:0]      secondBus,
   output logic                     secondBusOeN,
   output logic                     strobeOut,
   output logic                     strobeOeN,
   output logic                     rangeFlagOut,
   output logic                     rangeFlagOeN,
   output logic [7:0]               outputTiming,
   output logic [7:0]               firstTerm,
   output logic [7:0]               secondTerm,
   output logic [7:0]               divideFormat,
   output logic [7:0]               commonLevel
);
   typedef struct packed {
      logic [7:0]          pwr;
      logic [7:0]          fmt;
      logic [7:0]          dop;
      logic [7:0]          tim;
      logic [7:0]          termA;
      logic [7:0]          termB;
      logic [7:0]          div;
      logic [7:0]          cml;
      powerState_t         pst;
      logic [SAMPLE_W-1:0] busA;
      logic                busAOeN;
      logic [SAMPLE_W-1:0] busB;
      logic                busBOeN;
      logic                strobe;
      logic                strobeOeN;
      logic                range;
      logic                rangeOeN;
      logic                pend;
      logic [SAMPLE_W-1:0] trail;
   } state_t;

   state_t q, d;
   regWrite_t wrReq;
   logic [6:0] rdAddr;
   logic [7:0] rdData;

   serial_port u_serial (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .sclk    (sclk),
      .csN     (csN),
      .sdioIn  (sdioIn),
      .sdioOut (sdioOut),
      .sdioOeN (sdioOeN),
      .rdAddr  (rdAddr),
      .rdData  (rdData),
      .wrReq   (wrReq)
   );

   // Reverses pin order of one bus word.
   function automatic logic [SAMPLE_W-1:0] flip(
      input logic [SAMPLE_W-1:0] v
   );
      logic [SAMPLE_W-1:0] r;
      r = '0;
      for (int i = 0; i < SAMPLE_W; i++) begin
         r[i] = v[SAMPLE_W-1-i];
      end
      return r;
   endfunction

   // Maps one four-bit state set onto both channels.
   function automatic powerState_t decode(input logic [SET_W-1:0] s);
      powerState_t p;
      logic anyOn;
      anyOn = s[SET_FIRST] | s[SET_SECOND];
      p.avg = 1'b0;
      p.first = CH_OFF;
      p.second = CH_OFF;
      if (s[SET_AVG] && anyOn) begin
         p.avg = 1'b1;
         p.first = CH_ACTIVE;
         p.second = CH_ACTIVE;
      end else if (!anyOn) begin
         if (s[SET_STBY]) begin
            p.first = CH_STANDBY;
            p.second = CH_STANDBY;
         end else begin
            p.first = CH_OFF;
            p.second = CH_OFF;
         end
      end else if (s[SET_FIRST] && s[SET_SECOND]) begin
         p.first = CH_ACTIVE;
         p.second = CH_ACTIVE;
      end else if (s[SET_STBY]) begin
         p.first = s[SET_FIRST] ? CH_ACTIVE : CH_STANDBY;
         p.second = s[SET_SECOND] ? CH_ACTIVE : CH_STANDBY;
      end else begin
         p.first = s[SET_FIRST] ? CH_ACTIVE : CH_OFF;
         p.second = s[SET_SECOND] ? CH_ACTIVE : CH_OFF;
      end
      return p;
   endfunction

   // Register read decode; every unmapped address, including 07h and 09h, reads as zero.
   always_comb begin
      if (rdAddr == ADDR_PWR) begin
         rdData = q.pwr;
      end else if (rdAddr == ADDR_FMT) begin
         rdData = q.fmt;
      end else if (rdAddr == ADDR_DOP) begin
         rdData = q.dop;
      end else if (rdAddr == ADDR_TIM) begin
         rdData = q.tim;
      end else if (rdAddr == ADDR_TERM_A) begin
         rdData = q.termA;
      end else if (rdAddr == ADDR_TERM_B) begin
         rdData = q.termB;
      end else if (rdAddr == ADDR_DIV) begin
         rdData = q.div;
      end else if (rdAddr == ADDR_CML) begin
         rdData = q.cml;
      end else if (rdAddr == ADDR_SOFT) begin
         rdData = STATUS_BASE;
         rdData[STATUS_LOCK] = dllLocked;
      end else begin
         rdData = RST_ZERO;
      end
   end

   logic [SET_W-1:0]    setSel;
   logic [SAMPLE_W:0]   sum;
   logic [SAMPLE_W-1:0] mean;
   logic [SAMPLE_W-1:0] sleepVal;
   logic                sleepOeN;
   logic                oneBus;
   logic                busSel;
   logic                showA;
   logic                showB;
   logic [SAMPLE_W-1:0] leadVal;
   logic [SAMPLE_W-1:0] trailVal;

   always_comb begin
      d = q;
      setSel = powerDownPin ? q.pwr[2*SET_W-1:SET_W]
                            : q.pwr[SET_W-1:0];
      sum = {1'b0, firstSample} + {1'b0, secondSample};
      mean = sum[SAMPLE_W:1];
      sleepVal = {SAMPLE_W{q.dop[DOP_HI] & q.dop[DOP_LO]}};
      sleepOeN = ~q.dop[DOP_LO];
      busSel = q.fmt[FMT_BUS_SEL];
      oneBus = q.pst.avg | q.fmt[FMT_MUX];
      leadVal = busSel ? secondSample : firstSample;
      trailVal = busSel ? firstSample : secondSample;
      if (oneBus) begin
         showA = ~busSel;
         showB = busSel;
      end else begin
         showA = (q.pst.first == CH_ACTIVE);
         showB = (q.pst.second == CH_ACTIVE);
      end

      // Register writes; a soft reset reloads the defaults of the eight control registers only.
      if (wrReq.valid) begin
         if (wrReq.addr == ADDR_PWR) begin
            d.pwr = wrReq.data;
         end else if (wrReq.addr == ADDR_FMT) begin
            d.fmt = wrReq.data;
         end else if (wrReq.addr == ADDR_DOP) begin
            d.dop = wrReq.data;
         end else if (wrReq.addr == ADDR_TIM) begin
            d.tim = wrReq.data;
         end else if (wrReq.addr == ADDR_TERM_A) begin
            d.termA = wrReq.data;
         end else if (wrReq.addr == ADDR_TERM_B) begin
            d.termB = wrReq.data;
         end else if (wrReq.addr == ADDR_DIV) begin
            d.div = wrReq.data;
         end else if (wrReq.addr == ADDR_CML) begin
            d.cml = wrReq.data;
         end else if (wrReq.addr == ADDR_SOFT
                      && wrReq.data == SOFT_KEY) begin
            d.pwr = RST_PWR;
            d.fmt = RST_ZERO;
            d.dop = RST_ZERO;
            d.tim = RST_TIM;
            d.termA = RST_ZERO;
            d.termB = RST_ZERO;
            d.div = RST_ZERO;
            d.cml = RST_ZERO;
         end
      end

      // Power state follows the pin with one cycle of latency.
      d.pst = decode(setSel);

      d.strobe = 1'b0;
      d.strobeOeN = q.dop[DOP_STROBE];
      d.rangeOeN = q.dop[DOP_RANGE];
      d.busAOeN = showA ? 1'b0 : sleepOeN;
      d.busBOeN = showB ? 1'b0 : sleepOeN;
      if (!showA) begin
         d.busA = sleepVal;
      end
      if (!showB) begin
         d.busB = sleepVal;
      end

      if (sampleValid && (showA || showB)) begin
         d.strobe = 1'b1;
         d.range = overRange;
         d.pend = 1'b0;
         if (q.pst.avg) begin
            // The mean goes out on whichever bus was chosen.
            if (showA) begin
               d.busA = q.fmt[FMT_REV_A] ? flip(mean) : mean;
            end
            if (showB) begin
               d.busB = q.fmt[FMT_REV_B] ? flip(mean) : mean;
            end
         end else if (q.fmt[FMT_MUX]) begin
            // Interleaving needs two cycles per sample pair.
            d.pend = 1'b1;
            d.trail = trailVal;
            if (showA) begin
               d.busA = q.fmt[FMT_REV_A] ? flip(leadVal) : leadVal;
            end
            if (showB) begin
               d.busB = q.fmt[FMT_REV_B] ? flip(leadVal) : leadVal;
            end
         end else begin
            if (showA) begin
               d.busA = q.fmt[FMT_REV_A]
                        ? flip(firstSample) : firstSample;
            end
            if (showB) begin
               d.busB = q.fmt[FMT_REV_B]
                        ? flip(secondSample) : secondSample;
            end
         end
      end else if (q.pend) begin
         d.pend = 1'b0;
         d.strobe = 1'b1;
         if (showA) begin
            d.busA = q.fmt[FMT_REV_A] ? flip(q.trail) : q.trail;
         end
         if (showB) begin
            d.busB = q.fmt[FMT_REV_B] ? flip(q.trail) : q.trail;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{pwr: RST_PWR, fmt: RST_ZERO, dop: RST_ZERO,
                tim: RST_TIM, termA: RST_ZERO, termB: RST_ZERO,
                div: RST_ZERO, cml: RST_ZERO,
                pst: '{first: CH_ACTIVE, second: CH_ACTIVE,
                       avg: 1'b0},
                busA: '0, busAOeN: 1'b1, busB: '0, busBOeN: 1'b1,
                strobe: 1'b0, strobeOeN: 1'b1, range: 1'b0,
                rangeOeN: 1'b1, pend: 1'b0, trail: '0};
      end else begin
         q <= d;
      end
   end

   assign powerState = q.pst;
   assign firstBus = q.busA;
   assign firstBusOeN = q.busAOeN;
   assign secondBus = q.busB;
   assign secondBusOeN = q.busBOeN;
   assign strobeOut = q.strobe;
   assign strobeOeN = q.strobeOeN;
   assign rangeFlagOut = q.range;
   assign rangeFlagOeN = q.rangeOeN;
   assign outputTiming = q.tim;
   assign firstTerm = q.termA;
   assign secondTerm = q.termB;
   assign divideFormat = q.div;
   assign commonLevel = q.cml;
endmodule // adc_power_output_config_regs
`default_nettype wire

// [adc_power_output_config_regs_assertions.sv]
// Port-level assertions for the converter control-register bank.
`timescale 1ns/1ps
`default_nettype none
module adc_power_output_config_regs_assertions
   import cfg_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        csN,
   input wire logic        sdioOeN,
   input wire logic        powerDownPin,
   input wire logic        sampleValid,
   input wire powerState_t powerState,
   input wire logic        strobeOut,
   input wire logic [7:0]  outputTiming,
   input wire logic [7:0]  firstTerm
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_cs_float; csN |=> sdioOeN; endproperty
   a_cs_float: assert property (p_cs_float)
      else $error("serial line still driven after deselect");
   property p_drive_in_frame; !sdioOeN |-> !$past(csN); endproperty
   a_drive_in_frame: assert property (p_drive_in_frame)
      else $error("serial line driven outside a frame");
   property p_reg_quiet; $changed(outputTiming) |-> !$past(csN, 2); endproperty
   a_reg_quiet: assert property (p_reg_quiet)
      else $error("register changed without a selected frame");
   property p_reset_defaults;
      $rose(rst_n) |-> outputTiming == RST_TIM && firstTerm == RST_ZERO;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("register default wrong after reset");
   property p_reset_state;
      $rose(rst_n) |=> powerState == ($past(powerDownPin) ?
         {CH_OFF, CH_OFF, 1'b0} : {CH_ACTIVE, CH_ACTIVE, 1'b0});
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("default power state wrong for pin level");
   property p_no_mixed;
      !(powerState.first == CH_OFF && powerState.second == CH_STANDBY) &&
      !(powerState.first == CH_STANDBY && powerState.second == CH_OFF);
   endproperty
   a_no_mixed: assert property (p_no_mixed)
      else $error("one channel off while the other is in standby");
   property p_avg_both;
      powerState.avg |-> powerState.first == CH_ACTIVE &&
         powerState.second == CH_ACTIVE;
   endproperty
   a_avg_both: assert property (p_avg_both)
      else $error("averaging without both channels active");
   property p_strobe_cause;
      strobeOut |-> $past(sampleValid) || $past(sampleValid, 2);
   endproperty
   a_strobe_cause: assert property (p_strobe_cause)
      else $error("strobe without a recent sample");
endmodule // adc_power_output_config_regs_assertions
bind adc_power_output_config_regs adc_power_output_config_regs_assertions
   u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .csN(csN), .sdioOeN(sdioOeN),
   .powerDownPin(powerDownPin), .sampleValid(sampleValid),
   .powerState(powerState), .strobeOut(strobeOut),
   .outputTiming(outputTiming), .firstTerm(firstTerm));
`default_nettype wire

// [cfg_pkg.sv]
// Shared constants and types for the converter control-register bank.
// Function
// - Power-down pin low selects low nibble set, high selects high nibble set.
// - Reset value 03h: pin high shuts everything down, pin low gives full power.
// - Averaging bit of the selected set outputs the mean of both channels.
// - In averaging mode the bus-select bit picks the bus carrying the mean.
// - No averaging, no standby, one channel on: other channel fully off.
// - No averaging, standby set, one channel on: other channel in standby.
// - Standby set with both channel-on bits clear: both channels in standby.
// - No averaging, both channel-on bits set: both channels active, separate data.
// - Averaging with any channel-on bit: both active, averaged output, standby ignored.
// - Format bits 4 and 3 reverse pin order of second and first bus.
// - Interleaved mode: bus-select 0 uses first bus first-led, 1 second bus second-led.
// - Format bit 1 chooses dual buses or one interleaved bus.
// - Sleep pin field: 00 and 10 float, 01 drives low, 11 drives high.
// - Digital-power bit 1 floats the over-range flag driver.
// - Digital-power bit 0 floats the output data strobe driver.
// - Reset loads listed defaults: 03h at 00h, 6Dh at 03h, others zero.
// - Frame is sixteen bits MSB first: read flag, seven-bit address, eight data.
// - Serial pins sampled on rising serial clock only while chip select low.
// - Writing 5Ah to address 0Ah restores every control register default.
// - Reading address 0Ah returns status with bit 0 showing loop lock.
package cfg_pkg;
   localparam int SAMPLE_W = 10;
   localparam int SET_W    = 4;
   localparam logic [6:0] ADDR_PWR    = 7'h00;
   localparam logic [6:0] ADDR_FMT    = 7'h01;
   localparam logic [6:0] ADDR_DOP    = 7'h02;
   localparam logic [6:0] ADDR_TIM    = 7'h03;
   localparam logic [6:0] ADDR_TERM_A = 7'h04;
   localparam logic [6:0] ADDR_TERM_B = 7'h05;
   localparam logic [6:0] ADDR_DIV    = 7'h06;
   localparam logic [6:0] ADDR_CML    = 7'h08;
   localparam logic [6:0] ADDR_SOFT   = 7'h0A;
   localparam logic [7:0] RST_PWR     = 8'h03;
   localparam logic [7:0] RST_TIM     = 8'h6D;
   localparam logic [7:0] RST_ZERO    = 8'h00;
   localparam logic [7:0] SOFT_KEY    = 8'h5A;
   localparam logic [7:0] STATUS_BASE = 8'h14;
   localparam int STATUS_LOCK = 0;
   localparam int SET_AVG     = 3;
   localparam int SET_STBY    = 2;
   localparam int SET_SECOND  = 1;
   localparam int SET_FIRST   = 0;
   localparam int FMT_REV_B   = 4;
   localparam int FMT_REV_A   = 3;
   localparam int FMT_BUS_SEL = 2;
   localparam int FMT_MUX     = 1;
   localparam int DOP_HI      = 3;
   localparam int DOP_LO      = 2;
   localparam int DOP_RANGE   = 1;
   localparam int DOP_STROBE  = 0;
   localparam logic [2:0] LAST_BIT = 3'h7;
   typedef enum logic [1:0] {
      CH_OFF     = 2'b00,
      CH_STANDBY = 2'b01,
      CH_ACTIVE  = 2'b10
   } chanPower_t;
   typedef enum logic [1:0] {
      SER_CMD   = 2'b00,
      SER_WDATA = 2'b01,
      SER_RDATA = 2'b10,
      SER_DONE  = 2'b11
   } serState_t;
   typedef struct packed {
      logic       valid;
      logic [6:0] addr;
      logic [7:0] data;
   } regWrite_t;
   typedef struct packed {
      chanPower_t first;
      chanPower_t second;
      logic       avg;
   } powerState_t;
endpackage

// [host_model.sv]
// Host controller model that runs frames on the three-wire port.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic sys_clk,
   input  wire logic sdioWire,
   output logic      sclk,
   output logic      csN,
   output logic      sdioDrv
);
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      sdioDrv = 1'b0;
   end
   task automatic xfer(input logic rd, input logic [6:0] a,
                       input logic [7:0] wd, output logic [7:0] q);
      logic [15:0] f;
      f = {rd, a, wd};
      q = 8'h00;
      @(posedge sys_clk);
      #2 csN = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         // A released line shows a changing pattern, never the held bit.
         sdioDrv = (rd && i < 8) ? ~sdioDrv : f[i];
         repeat (3) @(posedge sys_clk);
         #2 sclk = 1'b1;
         if (i < 8) q[i] = sdioWire;
         repeat (3) @(posedge sys_clk);
         #2 sclk = 1'b0;
      end
      repeat (5) @(posedge sys_clk);
      #2 csN = 1'b1;
      repeat (3) @(posedge sys_clk);
      #2;
   endtask
endmodule // host_model
`default_nettype wire

// [serial_port.sv]
// Three-wire serial slave that turns frames into register accesses.
`timescale 1ns/1ps
`default_nettype none
module serial_port
   import cfg_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       sclk,
   input  wire logic       csN,
   input  wire logic       sdioIn,
   output logic            sdioOut,
   output logic            sdioOeN,
   output logic [6:0]      rdAddr,
   input  wire logic [7:0] rdData,
   output regWrite_t       wrReq
);
   typedef struct packed {
      logic       prevSclk;
      serState_t  state;
      logic [2:0] cnt;
      logic [7:0] ctrl;
      logic [7:0] data;
      logic [7:0] rdShift;
      logic       sdo;
      logic       oeN;
      regWrite_t  wr;
   } ser_t;
   ser_t q, d;
   logic rise, fall;
   assign rise = sclk & ~q.prevSclk;
   assign fall = ~sclk & q.prevSclk;
   assign rdAddr = {q.ctrl[5:0], sdioIn};
   always_comb begin
      d = q;
      d.prevSclk = sclk;
      d.wr.valid = 1'b0;
      if (csN) begin
         d.state = SER_CMD;
         d.cnt = '0;
         d.oeN = 1'b1;
      end else begin
         case (q.state)
            SER_CMD: begin
               if (rise) begin
                  d.ctrl = {q.ctrl[6:0], sdioIn};
                  d.cnt = q.cnt + 3'h1;
                  if (q.cnt == LAST_BIT) begin
                     d.rdShift = rdData;
                     d.state = q.ctrl[6] ? SER_RDATA : SER_WDATA;
                  end
               end
            end
            SER_WDATA: begin
               if (rise) begin
                  d.data = {q.data[6:0], sdioIn};
                  d.cnt = q.cnt + 3'h1;
                  if (q.cnt == LAST_BIT) begin
                     d.wr.valid = 1'b1;
                     d.wr.addr = q.ctrl[6:0];
                     d.wr.data = {q.data[6:0], sdioIn};
                     d.state = SER_DONE;
                  end
               end
            end
            SER_RDATA: begin
               if (fall) begin
                  d.sdo = q.rdShift[7];
                  d.rdShift = {q.rdShift[6:0], 1'b0};
                  d.oeN = 1'b0;
               end
               if (rise) begin
                  d.cnt = q.cnt + 3'h1;
                  if (q.cnt == LAST_BIT) begin
                     d.state = SER_DONE;
                  end
               end
            end
            SER_DONE: begin
               d.state = SER_DONE;
            end
            default: d.state = SER_CMD;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{prevSclk: 1'b0, state: SER_CMD, cnt: 3'h0,
                ctrl: 8'h00, data: 8'h00, rdShift: 8'h00,
                sdo: 1'b0, oeN: 1'b1,
                wr: '{valid: 1'b0, addr: 7'h00, data: 8'h00}};
      end else begin
         q <= d;
      end
   end
   assign sdioOut = q.sdo;
   assign sdioOeN = q.oeN;
   assign wrReq = q.wr;
endmodule // serial_port
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the converter control-register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import cfg_pkg::*;
;
   logic                     sys_clk, rst_n, pin, lock, sv, ovr, r;
   logic [SAMPLE_W-1:0]      sa, sb, fb, w;
   logic [7:0]               q, t0;
   wire logic                sclk, csN, sdioDrv, sdioOut, sdioOeN;
   wire logic                fOe, sOe, strb, strbOe, rng, rngOe;
   wire powerState_t         ps;
   wire logic [SAMPLE_W-1:0] fBus, sBus;
   wire logic [7:0]          tim, tA, tB, div, cml;
   wire logic [39:0]         outCat = {tim, tA, tB, div, cml};
   wire logic                sdioWire = sdioOeN ? sdioDrv : sdioOut;
   int                       mismatches, checks;
   localparam logic [6:0] AD [5] = '{ADDR_TIM, ADDR_TERM_A, ADDR_TERM_B,
                                     ADDR_DIV, ADDR_CML};
   localparam logic [7:0] CP [6] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h09, 8'h09};
   localparam logic [7:0] CF [6] = '{8'h00, 8'h18, 8'h02, 8'h16, 8'h00, 8'h0C};
   host_model u_host (.sys_clk(sys_clk), .sdioWire(sdioWire), .sclk(sclk),
                      .csN(csN), .sdioDrv(sdioDrv));
   adc_power_output_config_regs u_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .csN(csN),
      .sdioIn(sdioWire), .sdioOut(sdioOut), .sdioOeN(sdioOeN),
      .powerDownPin(pin), .dllLocked(lock), .firstSample(sa),
      .secondSample(sb), .sampleValid(sv), .overRange(ovr),
      .powerState(ps), .firstBus(fBus), .firstBusOeN(fOe),
      .secondBus(sBus), .secondBusOeN(sOe), .strobeOut(strb),
      .strobeOeN(strbOe), .rangeFlagOut(rng), .rangeFlagOeN(rngOe),
      .outputTiming(tim), .firstTerm(tA), .secondTerm(tB),
      .divideFormat(div), .commonLevel(cml));
   function automatic powerState_t expPs(input logic [3:0] n);
      powerState_t p;
      p.avg = n[3] & (n[1] | n[0]);
      p.first = (p.avg | n[0]) ? CH_ACTIVE : n[2] ? CH_STANDBY : CH_OFF;
      p.second = (p.avg | n[1]) ? CH_ACTIVE : n[2] ? CH_STANDBY : CH_OFF;
      return p;
   endfunction
   function automatic logic [SAMPLE_W-1:0] rv(input logic [SAMPLE_W-1:0] v,
                                              input logic rev);
      logic [SAMPLE_W-1:0] o;
      for (int i = 0; i < SAMPLE_W; i++) o[i] = rev ? v[SAMPLE_W-1-i] : v[i];
      return o;
   endfunction
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xf(input logic rd, input logic [6:0] a, input logic [7:0] d);
      u_host.xfer(rd, a, d, q);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      #1000000;
      mismatches++;
      stop_test();
   end
   initial begin
      logic [7:0] d, f;
      logic [3:0] m;
      powerState_t e;
      rst_n = 1'b0;
      pin = 1'b0;
      lock = 1'b1;
      sv = 1'b0;
      ovr = 1'b0;
      sa = '0;
      sb = '0;
      d = 8'($urandom(65));
      repeat (3) @(posedge sys_clk);
      #2 rst_n = 1'b1;
      for (int i = 0; i < 11; i++) begin
         if (i != 7) begin
            xf(1'b1, 7'(i), 8'h00);
            d = (i == 0) ? RST_PWR : (i == 3) ? RST_TIM : RST_ZERO;
            if (i == 10) d = STATUS_BASE | 8'h01;
            cmp(16'(q), 16'(d));
         end
      end
      $display("test defaults done");
      for (int k = 0; k < 5; k++) begin
         d = 8'($urandom);
         if (k == 0) t0 = d;
         xf(1'b0, AD[k], d);
         xf(1'b1, AD[k], 8'h00);
         cmp(16'(q), 16'(d));
         cmp(16'(outCat[39-8*k -: 8]), 16'(d));
      end
      d = 8'($urandom) & 8'h1E;
      xf(1'b0, ADDR_FMT, d);
      xf(1'b1, ADDR_FMT, 8'h00);
      cmp(16'(q), 16'(d));
      $display("test registers done");
      for (int i = 0; i < 16; i++) begin
         m = 4'($urandom);
         xf(1'b0, ADDR_PWR, {4'(i), m});
         for (int p = 0; p < 2; p++) begin
            @(posedge sys_clk);
            #2 pin = p[0];
            e = expPs(p[0] ? 4'(i) : m);
            repeat (2) @(posedge sys_clk);
            #2 cmp(16'(ps[4:1]), 16'(e[4:1]));
            cmp(16'(ps[0]), 16'(e[0]));
         end
      end
      $display("test power states done");
      pin = 1'b0;
      for (int c = 0; c < 6; c++) begin
         xf(1'b0, ADDR_PWR, CP[c]);
         xf(1'b0, ADDR_FMT, CF[c]);
         f = CF[c];
         r = f[2] ? f[4] : f[3];
         sa = SAMPLE_W'($urandom);
         sb = SAMPLE_W'($urandom);
         ovr = sa[0];
         @(posedge sys_clk);
         #2 sv = 1'b1;
         @(posedge sys_clk);
         #2 sv = 1'b0;
         cmp(16'(strb), 16'h0001);
         cmp(16'(rng), 16'(sa[0]));
         if (CP[c][3]) w = SAMPLE_W'(({1'b0, sa} + {1'b0, sb}) >> 1);
         else w = f[2] ? sb : sa;
         fb = f[2] ? sBus : fBus;
         if (f[1] | CP[c][3]) begin
            cmp(16'(fb), 16'(rv(w, r)));
            cmp(16'(f[2] ? fOe : sOe), 16'h0001);
         end else begin
            cmp(16'(fBus), 16'(rv(sa, f[3])));
            cmp(16'(sBus), 16'(rv(sb, f[4])));
         end
         if (f[1] & ~CP[c][3]) begin
            @(posedge sys_clk);
            #2 fb = f[2] ? sBus : fBus;
            w = f[2] ? sa : sb;
            cmp(16'(fb), 16'(rv(w, r)));
            cmp(16'(strb), 16'h0001);
         end
      end
      $display("test data path done");
      xf(1'b0, ADDR_PWR, 8'h01);
      xf(1'b0, ADDR_FMT, 8'h00);
      for (int k = 0; k < 4; k++) begin
         xf(1'b0, ADDR_DOP, 8'(k * 5));
         cmp(16'(sOe), 16'(k[0] == 1'b0));
         if (k[0]) cmp(16'(sBus), 16'({SAMPLE_W{k[1]}}));
         cmp(16'(strbOe), 16'(k[0]));
         cmp(16'(rngOe), 16'(k[1]));
      end
      $display("test sleep outputs done");
      xf(1'b0, ADDR_SOFT, 8'h33);
      cmp(16'(tim), 16'(t0));
      xf(1'b0, ADDR_SOFT, SOFT_KEY);
      cmp(16'(tim), 16'(RST_TIM));
      xf(1'b1, ADDR_PWR, 8'h00);
      cmp(16'(q), 16'(RST_PWR));
      pin = 1'b1;
      repeat (3) @(posedge sys_clk);
      #2 cmp(16'(ps), 16'({CH_OFF, CH_OFF, 1'b0}));
      lock = 1'b0;
      xf(1'b1, ADDR_SOFT, 8'h00);
      cmp(16'(q), 16'(STATUS_BASE));
      $display("test soft reset done");
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
